// >>> dcc_defs.svh
// Offsets, control-byte fields, reset values and timing counts of the DAQ card control logic
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_OFS_CTR0       4'h0
`define DCC_OFS_CTR1       4'h1
`define DCC_OFS_CTR2       4'h2
`define DCC_OFS_CTRL       4'h3
`define DCC_OFS_DA1_LO     4'h4
`define DCC_OFS_DA1_HI     4'h5
`define DCC_OFS_DA2_LO     4'h6
`define DCC_OFS_DA2_HI     4'h7
`define DCC_OFS_AD_LO      4'h4
`define DCC_OFS_AD_HI      4'h5
`define DCC_OFS_DI_LO      4'h6
`define DCC_OFS_DI_HI      4'h7
`define DCC_OFS_IRQ_CLR    4'h8
`define DCC_OFS_OPMODE     4'hB
`define DCC_OFS_SWTRIG     4'hC
`define DCC_OFS_DO_LO      4'hD
`define DCC_OFS_DO_HI      4'hE

`define DCC_CW_SEL_HI      7
`define DCC_CW_SEL_LO      6
`define DCC_CW_ACC_HI      5
`define DCC_CW_ACC_LO      4
`define DCC_CW_MODE_HI     3
`define DCC_CW_MODE_LO     1
`define DCC_CW_BCD         0
`define DCC_CW_SEL_BAD     2'h3
`define DCC_AD_HI_READY    4

`define DCC_OPMODE_RESET   3'h1

`define DCC_CONV_TIME_NS   8000
`define DCC_CLK_PERIOD_NS  5
`define DCC_CONV_CYCLES    (`DCC_CONV_TIME_NS / `DCC_CLK_PERIOD_NS)
`define DCC_CLK_HZ         200000000
`define DCC_TIMER_BASE_HZ  2000000
`define DCC_TICK_DIV       (`DCC_CLK_HZ / `DCC_TIMER_BASE_HZ)

`endif

// >>> dcc_pkg.sv
// Types shared by the DAQ card control logic
package dcc_pkg;
   typedef enum logic [2:0] {
      DCC_OP_OFF        = 3'h0,
      DCC_OP_SW_POLL    = 3'h1,
      DCC_OP_PACER_DMA  = 3'h2,
      DCC_OP_PACER_IRQ  = 3'h6
   } dcc_op_mode_t;

   typedef enum logic [1:0] {
      DCC_IDLE = 2'h0,
      DCC_CONV = 2'h1,
      DCC_DONE = 2'h3
   } dcc_conv_state_t;

   typedef enum logic [1:0] {
      DCC_ACC_LATCH = 2'h0,
      DCC_ACC_LSB   = 2'h1,
      DCC_ACC_MSB   = 2'h2,
      DCC_ACC_BOTH  = 2'h3
   } dcc_access_t;
endpackage : dcc_pkg

// >>> dcc_counter.sv
// One programmable 16-bit interval counter with six modes and binary or BCD counting
`timescale 1ns/100ps
module dcc_counter (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       gate,
   input  wire logic       ctrl_wr,
   input  wire logic [5:0] ctrl,
   input  wire logic       data_wr,
   input  wire logic       data_rd,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic            out
);
   import dcc_pkg::*;

   dcc_access_t access;
   logic [2:0]  mode;
   logic        bcd;
   logic [15:0] reload;
   logic [15:0] count;
   logic [15:0] latch;
   logic        latched;
   logic        wr_ptr;
   logic        rd_ptr;
   logic        load_pend;
   logic        armed;
   logic        running;
   logic        trig_pend;
   logic        gate_q;

   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r = v;
      borrow = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (borrow) begin
            if (r[i*4 +: 4] == 4'h0) begin
               r[i*4 +: 4] = 4'h9;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
               borrow = 1'b0;
            end
         end
      end
      return r;
   endfunction : bcd_dec

   // Mode field with the don't-care top bit folded for modes 2 and 3
   wire [2:0]  new_mode   = ctrl[2] ? {1'b0, ctrl[2:1]} : ctrl[3:1];
   wire        latch_cmd  = ctrl_wr & (dcc_access_t'(ctrl[5:4]) == DCC_ACC_LATCH);
   wire        hw_mode    = (mode == 3'h1) | (mode == 3'h5);
   wire        gate_rise  = gate & ~gate_q;
   wire [15:0] dec1       = bcd ? bcd_dec(count) : count - 16'h0001;
   wire [15:0] dec2       = bcd ? bcd_dec(dec1) : dec1 - 16'h0001;
   wire [15:0] next_count = (mode == 3'h3) ? dec2 : dec1;
   wire        start_load = hw_mode ? trig_pend : load_pend;
   wire [15:0] rd_src     = latched ? latch : count;
   wire        rd_high    = (access == DCC_ACC_MSB) | ((access == DCC_ACC_BOTH) & rd_ptr);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         access    <= DCC_ACC_BOTH;
         mode      <= 3'h0;
         bcd       <= 1'b0;
         reload    <= 16'h0000;
         count     <= 16'h0000;
         latch     <= 16'h0000;
         latched   <= 1'b0;
         wr_ptr    <= 1'b0;
         rd_ptr    <= 1'b0;
         load_pend <= 1'b0;
         armed     <= 1'b0;
         running   <= 1'b0;
         trig_pend <= 1'b0;
         gate_q    <= 1'b0;
         out       <= 1'b0;
         rdata     <= 8'h00;
      end else begin
         gate_q <= gate;
         rdata  <= rd_high ? rd_src[15:8] : rd_src[7:0];
         if (tick && start_load) begin
            count     <= reload;
            running   <= 1'b1;
            load_pend <= 1'b0;
            trig_pend <= 1'b0;
            if (mode == 3'h1) begin
               out <= 1'b0;
            end
         end else if (tick && running && (gate || hw_mode)) begin
            count <= next_count;
            unique case (mode)
               3'h0, 3'h1: if (count == 16'h0001) out <= 1'b1;
               3'h2: begin
                  if (count == 16'h0002) begin
                     out <= 1'b0;
                  end else if (count == 16'h0001) begin
                     out   <= 1'b1;
                     count <= reload;
                  end
               end
               3'h3: begin
                  if ((count == 16'h0002) || (count == 16'h0001)) begin
                     out   <= ~out;
                     count <= reload;
                  end
               end
               3'h4, 3'h5: out <= (count != 16'h0001);
            endcase
         end
         if (gate_rise && hw_mode && armed) begin
            trig_pend <= 1'b1;
         end
         if (latch_cmd) begin
            if (!latched) begin
               latch   <= count;
               latched <= 1'b1;
            end
         end else if (ctrl_wr) begin
            access    <= dcc_access_t'(ctrl[5:4]);
            mode      <= new_mode;
            bcd       <= ctrl[0];
            out       <= (new_mode != 3'h0);
            running   <= 1'b0;
            load_pend <= 1'b0;
            trig_pend <= 1'b0;
            armed     <= 1'b0;
            latched   <= 1'b0;
            wr_ptr    <= 1'b0;
            rd_ptr    <= 1'b0;
         end else begin
            if (data_wr) begin
               unique case (access)
                  DCC_ACC_LSB: reload <= {8'h00, wdata};
                  DCC_ACC_MSB: reload <= {wdata, 8'h00};
                  DCC_ACC_BOTH: begin
                     wr_ptr <= ~wr_ptr;
                     if (wr_ptr) begin
                        reload[15:8] <= wdata;
                     end else begin
                        reload[7:0] <= wdata;
                     end
                  end
                  default: reload <= reload;
               endcase
               if ((access != DCC_ACC_BOTH) || wr_ptr) begin
                  load_pend <= 1'b1;
                  armed     <= 1'b1;
                  if (mode == 3'h0) begin
                     out <= 1'b0;
                  end
               end
            end
            if (data_rd) begin
               if (access == DCC_ACC_BOTH) begin
                  rd_ptr <= ~rd_ptr;
               end
               if ((access != DCC_ACC_BOTH) || rd_ptr) begin
                  latched <= 1'b0;
               end
            end
         end
      end
   end
endmodule : dcc_counter

// >>> dcc_top.sv
// Control logic of the data acquisition card: host registers, A/D sequencing, D/A, DIO, timer
//
// How it works
// - External trigger rising edge starts a conversion
// - External trigger works with DMA, interrupt, polling
// - Operation mode register selects the transfer method
// - Ready flag set at end, cleared reading low byte
// - Every conversion completes within eight microseconds
// - Interrupt mode raises request when result ready
// - DMA mode requests a transfer per result
// - Analog code held until high byte written
// - Digital ports are accessed as whole bytes
// - Three 16-bit counters, six modes each
// - Counter one clocks counter two as pacer
// - Pacer base is 2 MHz divided clock
// - Counter zero clock, gate, output on pins
// - Timer occupies offsets zero to three
// - Control bits 7:6 select counter, 11 illegal
// - Control bits 5:4 select latch or byte access
// - Control bits 3:1 select counter mode
// - Control bit 0 selects binary or BCD
// - Modes zero to five in documented order
// - Mode bits: off, soft-poll default, pacer-DMA, pacer-irq
// - Interrupt flag set per conversion, cleared by write
// - Write to trigger offset starts one conversion
// - External source selected masks software and pacer
`include "dcc_defs.svh"
`timescale 1ns/100ps
module dcc_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  io_addr,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   input  wire logic        external_trigger_input,
   input  wire logic        ext_trig_select,
   input  wire logic        ctr0_clk,
   input  wire logic        ctr0_gate,
   output logic             ctr0_out,
   output logic             pacer_trigger,
   output logic             adc_start,
   input  wire logic [11:0] adc_result_in,
   output logic      [11:0] ad_result,
   output logic             conversion_ready_flag,
   output logic             irq,
   output logic             dma_req,
   input  wire logic        dma_ack,
   input  wire logic [15:0] di,
   output logic      [15:0] dout,
   output logic      [11:0] analog_output_one,
   output logic      [11:0] analog_output_two,
   output logic      [2:0]  op_mode
);
   import dcc_pkg::*;

   localparam int CONV_LAST = `DCC_CONV_CYCLES - 2;   // Result and flags stand 8 us after the trigger
   localparam int TICK_LAST = `DCC_TICK_DIV - 1;

   // Pin synchronisers: bit 0 is the first flop and only feeds bit 1
   logic [2:0]  ext_s;
   logic [2:0]  c0clk_s;
   logic [1:0]  c0gate_s;
   logic [1:0]  sel_s;
   logic [1:0]  ack_s;
   logic [11:0] adc_q1;
   logic [11:0] adc_q2;
   logic [15:0] di_q1;
   logic [15:0] di_q2;

   logic [6:0]      base_cnt;
   logic            base_tick;
   logic [2:0]      ctr_out;
   logic [2:0]      ctr_out_q;
   logic [7:0]      ctr_rdata [3];
   logic [2:0]      ctr_tick;
   logic [2:0]      ctr_gate;
   dcc_conv_state_t state;
   dcc_conv_state_t next_state;
   logic [10:0]     conv_cnt;
   logic [7:0]      da1_lo;
   logic [7:0]      da2_lo;
   logic            irq_flag;
   logic [7:0]      rd_mux;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_s    <= 3'h0;
         c0clk_s  <= 3'h0;
         c0gate_s <= 2'h0;
         sel_s    <= 2'h0;
         ack_s    <= 2'h0;
         adc_q1   <= 12'h000;
         adc_q2   <= 12'h000;
         di_q1    <= 16'h0000;
         di_q2    <= 16'h0000;
      end else begin
         ext_s    <= {ext_s[1:0], external_trigger_input};
         c0clk_s  <= {c0clk_s[1:0], ctr0_clk};
         c0gate_s <= {c0gate_s[0], ctr0_gate};
         sel_s    <= {sel_s[0], ext_trig_select};
         ack_s    <= {ack_s[0], dma_ack};
         adc_q1   <= adc_result_in;
         adc_q2   <= adc_q1;
         di_q1    <= di;
         di_q2    <= di_q1;
      end
   end

   // Host register decode
   wire wr_ctrl    = io_wr & (io_addr == `DCC_OFS_CTRL);
   wire wr_da1_lo  = io_wr & (io_addr == `DCC_OFS_DA1_LO);
   wire wr_da1_hi  = io_wr & (io_addr == `DCC_OFS_DA1_HI);
   wire wr_da2_lo  = io_wr & (io_addr == `DCC_OFS_DA2_LO);
   wire wr_da2_hi  = io_wr & (io_addr == `DCC_OFS_DA2_HI);
   wire wr_irq_clr = io_wr & (io_addr == `DCC_OFS_IRQ_CLR);
   wire wr_opmode  = io_wr & (io_addr == `DCC_OFS_OPMODE);
   wire wr_swtrig  = io_wr & (io_addr == `DCC_OFS_SWTRIG);
   wire wr_do_lo   = io_wr & (io_addr == `DCC_OFS_DO_LO);
   wire wr_do_hi   = io_wr & (io_addr == `DCC_OFS_DO_HI);
   wire rd_ad_lo   = io_rd & (io_addr == `DCC_OFS_AD_LO);
   wire [1:0] cw_sel = io_wdata[`DCC_CW_SEL_HI:`DCC_CW_SEL_LO];

   // Timer base: one tick per period of the 2 MHz count clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base_cnt  <= 7'h00;
         base_tick <= 1'b0;
      end else begin
         base_tick <= (base_cnt == 7'(TICK_LAST));
         base_cnt  <= (base_cnt == 7'(TICK_LAST)) ? 7'h00 : base_cnt + 7'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctr_out_q <= 3'h0;
      end else begin
         ctr_out_q <= ctr_out;
      end
   end

   assign ctr_tick[0] = c0clk_s[1] & ~c0clk_s[2];
   assign ctr_tick[1] = base_tick;
   assign ctr_tick[2] = ctr_out[1] & ~ctr_out_q[1];
   assign ctr_gate[0] = c0gate_s[1];
   assign ctr_gate[1] = 1'b1;
   assign ctr_gate[2] = 1'b1;

   generate
      for (genvar g = 0; g < 3; g++) begin : g_ctr
         wire sel_hit = (cw_sel == 2'(g)) & (cw_sel != `DCC_CW_SEL_BAD);
         wire at_ofs  = (io_addr == 4'(g));
         dcc_counter u_ctr (
            .clk     (clk),
            .rst     (rst),
            .tick    (ctr_tick[g]),
            .gate    (ctr_gate[g]),
            .ctrl_wr (wr_ctrl & sel_hit),
            .ctrl    (io_wdata[`DCC_CW_ACC_HI:`DCC_CW_BCD]),
            .data_wr (io_wr & at_ofs),
            .data_rd (io_rd & at_ofs),
            .wdata   (io_wdata),
            .rdata   (ctr_rdata[g]),
            .out     (ctr_out[g])
         );
      end
   endgenerate

   assign ctr0_out      = ctr_out[0];
   assign pacer_trigger = ctr_out[2];

   // Trigger selection; conversions requested mid-conversion are dropped
   wire ext_sel    = sel_s[1];
   wire ext_rise   = ext_s[1] & ~ext_s[2];
   wire pacer_rise = ctr_out[2] & ~ctr_out_q[2];
   wire pacer_mode = (op_mode == DCC_OP_PACER_DMA) | (op_mode == DCC_OP_PACER_IRQ);
   wire sw_trig    = wr_swtrig & (op_mode != DCC_OP_OFF);
   wire pace_trig  = pacer_rise & pacer_mode;
   wire trig       = ext_sel ? ext_rise : (sw_trig | pace_trig);
   wire conv_start = trig & (state == DCC_IDLE);
   wire conv_end   = (state == DCC_CONV) & (conv_cnt == 11'(CONV_LAST));
   wire done_evt   = (state == DCC_DONE);

   always_comb begin
      next_state = state;
      unique case (state)
         DCC_IDLE: if (conv_start) next_state = DCC_CONV;
         DCC_CONV: if (conv_end) next_state = DCC_DONE;
         DCC_DONE: next_state = DCC_IDLE;
         default:  next_state = DCC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= DCC_IDLE;
         conv_cnt  <= 11'h000;
         adc_start <= 1'b0;
         ad_result <= 12'h000;
      end else begin
         state     <= next_state;
         adc_start <= conv_start;
         conv_cnt  <= (state == DCC_CONV) ? conv_cnt + 11'h001 : 11'h000;
         if (conv_end) begin
            ad_result <= adc_q2;
         end
      end
   end

   // Completion flags: a new result wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conversion_ready_flag <= 1'b0;
         irq_flag              <= 1'b0;
         dma_req               <= 1'b0;
      end else begin
         if (done_evt) begin
            conversion_ready_flag <= 1'b1;
         end else if (rd_ad_lo) begin
            conversion_ready_flag <= 1'b0;
         end
         if (done_evt && (op_mode == DCC_OP_PACER_IRQ)) begin
            irq_flag <= 1'b1;
         end else if (wr_irq_clr) begin
            irq_flag <= 1'b0;
         end
         if (done_evt && (op_mode == DCC_OP_PACER_DMA)) begin
            dma_req <= 1'b1;
         end else if (ack_s[1]) begin
            dma_req <= 1'b0;
         end
      end
   end

   assign irq = irq_flag;

   // Mode, analog and digital output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_mode           <= `DCC_OPMODE_RESET;
         da1_lo            <= 8'h00;
         da2_lo            <= 8'h00;
         analog_output_one <= 12'h000;
         analog_output_two <= 12'h000;
         dout              <= 16'h0000;
      end else begin
         if (wr_opmode) begin
            op_mode <= io_wdata[2:0];
         end
         if (wr_da1_lo) begin
            da1_lo <= io_wdata;
         end
         if (wr_da1_hi) begin
            analog_output_one <= {io_wdata[3:0], da1_lo};
         end
         if (wr_da2_lo) begin
            da2_lo <= io_wdata;
         end
         if (wr_da2_hi) begin
            analog_output_two <= {io_wdata[3:0], da2_lo};
         end
         if (wr_do_lo) begin
            dout[7:0] <= io_wdata;
         end
         if (wr_do_hi) begin
            dout[15:8] <= io_wdata;
         end
      end
   end

   // Read mux; write-only and unmapped offsets read as zero
   always_comb begin
      unique case (io_addr)
         `DCC_OFS_CTR0:  rd_mux = ctr_rdata[0];
         `DCC_OFS_CTR1:  rd_mux = ctr_rdata[1];
         `DCC_OFS_CTR2:  rd_mux = ctr_rdata[2];
         `DCC_OFS_AD_LO: rd_mux = ad_result[7:0];
         `DCC_OFS_AD_HI: rd_mux = {3'h0, conversion_ready_flag, ad_result[11:8]};
         `DCC_OFS_DI_LO: rd_mux = di_q2[7:0];
         `DCC_OFS_DI_HI: rd_mux = di_q2[15:8];
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= rd_mux;
      end
   end
endmodule : dcc_top

// >>> dcc_checker.sv
// Port-level assertions of the DAQ card control logic
`timescale 1ns/100ps
module dcc_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  io_addr,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic [7:0]  io_wdata,
   input wire logic        ext_trig_select,
   input wire logic        external_trigger_input,
   input wire logic        adc_start,
   input wire logic        conversion_ready_flag,
   input wire logic        irq,
   input wire logic        dma_req,
   input wire logic        dma_ack,
   input wire logic [11:0] analog_output_one,
   input wire logic [2:0]  op_mode
);
   logic [15:0] conv_cnt;
   logic [3:0]  wdata_nib;
   logic [2:0]  wdata_mode;
   assign wdata_nib  = io_wdata[3:0];
   assign wdata_mode = io_wdata[2:0];
   // Cycles since the converter was started
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         conv_cnt <= 16'h0000;
      else if (adc_start)
         conv_cnt <= 16'h0001;
      else if (conv_cnt != 16'h0000 && conv_cnt != 16'hffff)
         conv_cnt <= conv_cnt + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_sw_write;
      io_wr && io_addr == 4'hC;
   endsequence
   sequence s_ext_held;
      (ext_trig_select && !external_trigger_input) [*3];
   endsequence
   a_start_one_pulse: assert property (adc_start |=> !adc_start)
      else $error("start pulse too long");
   a_conv_time_exact: assert property ($rose(conversion_ready_flag) |-> conv_cnt == 16'h0640)
      else $error("conversion length wrong");
   a_irq_needs_mode: assert property ($rose(irq) |-> op_mode == 3'h6)
      else $error("irq outside interrupt mode");
   a_dma_needs_mode: assert property ($rose(dma_req) |-> op_mode == 3'h2)
      else $error("dma request outside dma mode");
   a_dma_holds_req: assert property (dma_req && !dma_ack |=> dma_req)
      else $error("dma request dropped early");
   a_da_high_update: assert property (io_wr && io_addr == 4'h5 |=> analog_output_one[11:8] == $past(wdata_nib))
      else $error("analog high nibble wrong");
   a_da_held_low: assert property (!$stable(analog_output_one) |-> $past(io_wr) && $past(io_addr) == 4'h5)
      else $error("analog output moved without high byte");
   a_irq_clear_write: assert property (io_wr && io_addr == 4'h8 |=> !irq || conv_cnt == 16'h0640)
      else $error("irq not cleared");
   a_ready_clear_read: assert property (io_rd && io_addr == 4'h4 |=> !conversion_ready_flag || conv_cnt == 16'h0640)
      else $error("ready not cleared by low read");
   a_op_mode_write: assert property (io_wr && io_addr == 4'hB |=> op_mode == $past(wdata_mode))
      else $error("op mode not written");
   a_ext_masks_sw: assert property (s_ext_held ##0 s_sw_write |=> !adc_start)
      else $error("software trigger not masked");
endmodule : dcc_checker

bind dcc_top dcc_checker chk_i (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
   .io_rd(io_rd), .io_wdata(io_wdata), .ext_trig_select(ext_trig_select),
   .external_trigger_input(external_trigger_input), .adc_start(adc_start),
   .conversion_ready_flag(conversion_ready_flag), .irq(irq), .dma_req(dma_req),
   .dma_ack(dma_ack), .analog_output_one(analog_output_one), .op_mode(op_mode));

// >>> dcc_host_model.sv
// Host model driving the byte-wide register bus
`timescale 1ns/100ps
module dcc_host_model (
   input  wire logic       clk,
   output logic      [3:0] io_addr,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata
);
   initial begin
      io_addr  = 4'hF;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
      io_wdata = 8'h00;
   end
   // One bus cycle; address and data are scrambled once released
   task automatic cycle(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      #1;
      io_addr  = a;
      io_wdata = d;
      io_wr    = w;
      io_rd    = ~w;
      @(posedge clk);
      #1;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
      io_addr  = ~a;
      io_wdata = ~d;
   endtask : cycle
endmodule : dcc_host_model

// >>> daq_card_control_logic_tb_top.sv
// Self-checking bench of the DAQ card control logic
`timescale 1ns/100ps
module daq_card_control_logic_tb_top;
   logic        clk, rst, ext_sel, ext_in, c0clk, dma_ack, c0out, rdy, irq, dma_req, pacer;
   logic [3:0]  io_addr;
   logic        io_wr, io_rd;
   logic [7:0]  io_wdata, io_rdata;
   logic [11:0] adc_res, dac1, dac2, res;
   logic [15:0] di, dout, v;
   logic [2:0]  op_mode;
   logic [31:0] seed = 32'h4d28;
   logic [7:0]  exp_q[$];
   int          errors = 0;
   int          num_checks = 0;
   int          n;
   dcc_host_model host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata));
   dcc_top uut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .external_trigger_input(ext_in),
      .ext_trig_select(ext_sel), .ctr0_clk(c0clk), .ctr0_gate(1'b1), .ctr0_out(c0out),
      .pacer_trigger(pacer), .adc_start(), .adc_result_in(adc_res), .ad_result(),
      .conversion_ready_flag(rdy), .irq(irq), .dma_req(dma_req), .dma_ack(dma_ack),
      .di(di), .dout(dout), .analog_output_one(dac1), .analog_output_two(dac2),
      .op_mode(op_mode));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (e !== s) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.cycle(a, 8'h00, 1'b0);
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host.cycle(a, d, 1'b1);
   endtask : wr
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wait_ready();
      n = 0;
      while (rdy !== 1'b1 && n < 4000) begin
         cyc(1);
         n++;
      end
   endtask : wait_ready
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Read data lands on the sampling edge and is checked 2 ns later
   initial forever begin
      @(posedge clk);
      if (io_rd === 1'b1) begin
         #2;
         chk("io_rdata", {8'h00, exp_q.pop_front()}, {8'h00, io_rdata});
      end
   end
   initial begin
      #100000;
      errors++;
      conclude();
   end
   initial begin
      {rst, ext_sel, ext_in, c0clk, dma_ack, di, adc_res} = {5'h10, 16'h0000, 12'h000};
      cyc(4);
      rst = 1'b0;
      chk("op_mode", 16'h0001, {13'h0000, op_mode});
      for (int ch = 0; ch < 2; ch++) begin
         seed = lfsr(seed);
         v = seed[15:0];
         wr(4'h4 + 4'(2 * ch), v[7:0]);
         cyc(2);
         chk("da_low_held", 16'h0000, {4'h0, ch ? dac2 : dac1});
         wr(4'h5 + 4'(2 * ch), v[15:8]);
         cyc(2);
         chk("da_code", {4'h0, v[11:0]}, {4'h0, ch ? dac2 : dac1});
      end
      seed = lfsr(seed);
      di = seed[23:8];
      wr(4'hD, seed[7:0]);
      wr(4'hE, seed[15:8]);
      cyc(1);
      chk("dout", seed[15:0], dout);
      rd(4'h6, di[7:0]);
      rd(4'h7, di[15:8]);
      rd(4'h9, 8'h00);
      wr(4'h3, 8'h30);
      wr(4'h0, seed[7:0]);
      wr(4'h0, seed[15:8]);
      c0clk = 1'b1;
      cyc(4);
      c0clk = 1'b0;
      cyc(4);
      chk("ctr0_out", 16'h0000, {15'h0000, c0out});
      wr(4'h3, 8'hD0);
      wr(4'h3, 8'h00);
      rd(4'h0, seed[7:0]);
      rd(4'h0, seed[15:8]);
      seed = lfsr(seed);
      res = seed[11:0];
      adc_res = res;
      wr(4'hC, 8'h5A);
      wait_ready();
      chk("conv_fast", 16'h0001, {15'h0000, n <= 1600});
      rd(4'h5, {3'h0, 1'b1, res[11:8]});
      rd(4'h4, res[7:0]);
      cyc(2);
      chk("ready_cleared", 16'h0000, {15'h0000, rdy});
      ext_sel = 1'b1;
      for (int m = 0; m < 2; m++) begin
         wr(4'hB, m ? 8'h02 : 8'h06);
         cyc(3);
         wr(4'hC, 8'h00);
         cyc(8);
         seed = lfsr(seed);
         adc_res = seed[11:0];
         ext_in = 1'b1;
         cyc(4);
         ext_in = 1'b0;
         wait_ready();
         chk("irq", {15'h0000, m == 0}, {15'h0000, irq});
         chk("dma_req", {15'h0000, m == 1}, {15'h0000, dma_req});
         wr(4'h8, 8'hFF);
         dma_ack = 1'b1;
         cyc(4);
         dma_ack = 1'b0;
         chk("irq_clear", 16'h0000, {15'h0000, irq});
         chk("dma_clear", 16'h0000, {15'h0000, dma_req});
         rd(4'h4, seed[7:0]);
      end
      wr(4'h3, 8'h54);
      wr(4'h1, 8'h02);
      wr(4'h3, 8'h94);
      wr(4'h2, 8'h02);
      wr(4'hB, 8'h06);
      ext_sel = 1'b0;
      wait_ready();
      chk("pacer_conv", 16'h0001, {15'h0000, rdy});
      chk("pacer_irq", 16'h0001, {15'h0000, irq});
      // Align to a pacer rising edge, then time one full period
      while (pacer !== 1'b0) cyc(1);
      while (pacer !== 1'b1) cyc(1);
      n = 0;
      while (pacer !== 1'b0 && n < 1000) begin
         cyc(1);
         n++;
      end
      while (pacer !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      chk("pacer_period", 16'h0190, n[15:0]);
      cyc(4);
      conclude();
   end
endmodule : daq_card_control_logic_tb_top
